// ==== core/sru_async_serial_unit.sv ====
// async serial unit: ahb-lite register slave, receive and transmit shifters
// assumes synchronous rxd, one clock ref_clk, zero-wait-state single-word bus
`timescale 1ns/1ps
module sru_async_serial_unit
	import sru_pkg::*;
#(
	parameter int DIV_W = 16
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// serial pins
	input wire logic rxd,
	output logic txd
);
	// ********************
	// registers
	// ********************
	logic [7:0] received_byte;
	logic [7:0] tx_holding_byte;
	logic [3:0] serial_control_reg;
	logic [DIV_W-1:0] bit_rate_reg;
	logic rx_full_flag, overrun_flag, framing_flag, parity_flag, tx_empty;
	logic [7:0] rx_shifter, tx_shifter, wr_addr;
	logic [DIV_W-1:0] div_cnt;
	sru_state_e rx_st, tx_st;
	logic [3:0] rx_ph, tx_ph;
	logic [2:0] rx_bit, tx_bit;
	logic tick, rx_par, tx_par_acc, wr_pend, addr_ok, bus_wr, stat_wr, err_any;
	logic rx_samp, rx_done, rx_perr, rx_ferr, tx_load, tx_step;
	logic [31:0] next_rdata;

	// ********************
	// bus slave
	// ********************
	// zero wait states: hrdata loads at the address-phase edge
	assign addr_ok = hsel && hready && htrans == SRU_HTRANS_NONSEQ;
	assign bus_wr = wr_pend;
	assign stat_wr = bus_wr && wr_addr == SRU_OFS_STAT;

	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (haddr[7:0])
			SRU_OFS_RXB: next_rdata[7:0] = received_byte;
			SRU_OFS_TXH: next_rdata[7:0] = tx_holding_byte;
			SRU_OFS_STAT: begin
				next_rdata[SRU_ST_FULL] = rx_full_flag;
				next_rdata[SRU_ST_OVR] = overrun_flag;
				next_rdata[SRU_ST_FRM] = framing_flag;
				next_rdata[SRU_ST_PAR] = parity_flag;
				next_rdata[SRU_ST_TXE] = tx_empty;
				next_rdata[SRU_ST_BUSY] = tx_st != SRU_IDLE;
			end
			SRU_OFS_CTRL: next_rdata[3:0] = serial_control_reg;
			SRU_OFS_RATE: next_rdata[DIV_W-1:0] = bit_rate_reg;
			// shifters have no address; unmapped reads return zero
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= addr_ok && hwrite;
			if (addr_ok) begin
				wr_addr <= haddr[7:0];
				if (!hwrite) begin
					hrdata <= next_rdata;
				end
			end
		end
	end

	// received_byte has no write path; bus writes to it are dropped
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_holding_byte <= SRU_TXH_RST;
			serial_control_reg <= SRU_CTRL_RST;
			bit_rate_reg <= DIV_W'(SRU_RATE_RST);
		end else if (bus_wr) begin
			if (wr_addr == SRU_OFS_TXH) tx_holding_byte <= hwdata[7:0];
			if (wr_addr == SRU_OFS_CTRL) serial_control_reg <= hwdata[3:0];
			if (wr_addr == SRU_OFS_RATE) bit_rate_reg <= hwdata[DIV_W-1:0];
		end
	end

	// ********************
	// oversampling tick
	// ********************
	// sixteen ticks per bit; period is bit_rate_reg + 1 clocks
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= div_cnt == bit_rate_reg;
			div_cnt <= (div_cnt >= bit_rate_reg) ? '0 : div_cnt + 1'b1;
		end
	end

	// ********************
	// receiver
	// ********************
	assign err_any = overrun_flag || framing_flag || parity_flag;
	assign rx_samp = tick && rx_ph == SRU_OVS_LAST;
	assign rx_done = rx_samp && rx_st == SRU_STOP;
	assign rx_ferr = !rxd;
	assign rx_perr = serial_control_reg[SRU_CT_PEN]
		&& ((^rx_shifter ^ rx_par) != serial_control_reg[SRU_CT_ODD]);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_st <= SRU_IDLE;
			rx_ph <= 4'h0;
			rx_bit <= 3'h0;
			rx_par <= 1'b0;
			rx_shifter <= 8'h00;
		end else begin
			if (tick) rx_ph <= rx_ph + 4'h1;
			unique case (rx_st)
				SRU_IDLE: begin
					// held off while any error flag stands
					if (serial_control_reg[SRU_CT_RXEN] && !err_any && !rxd) begin
						rx_st <= SRU_START;
						rx_ph <= 4'h0;
					end
				end
				SRU_START: begin
					// mid-bit recheck filters glitches on the start edge
					if (tick && rx_ph == SRU_OVS_MID) begin
						rx_st <= rxd ? SRU_IDLE : SRU_DATA;
						rx_ph <= 4'h0;
						rx_bit <= 3'h0;
					end
				end
				SRU_DATA: begin
					if (rx_samp) begin
						rx_shifter <= {rxd, rx_shifter[7:1]};
						rx_bit <= rx_bit + 3'h1;
						if (rx_bit == SRU_BIT_LAST) begin
							rx_st <= serial_control_reg[SRU_CT_PEN] ? SRU_PARITY : SRU_STOP;
						end
					end
				end
				SRU_PARITY: begin
					if (rx_samp) begin
						rx_par <= rxd;
						rx_st <= SRU_STOP;
					end
				end
				SRU_STOP: begin
					// back to idle at once: the next start bit is caught
					if (rx_samp) rx_st <= SRU_IDLE;
				end
				default: rx_st <= SRU_IDLE;
			endcase
		end
	end

	// overrun drops the byte; otherwise store even when errored
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			received_byte <= SRU_RXB_RST;
		end else if (rx_done && !rx_full_flag) begin
			received_byte <= rx_shifter;
		end
	end

	// set wins over a software clear; only writing zero clears
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_full_flag <= 1'b0;
			overrun_flag <= 1'b0;
			framing_flag <= 1'b0;
			parity_flag <= 1'b0;
		end else begin
			// errored frames leave rx_full_flag as it was
			if (rx_done && !rx_full_flag && !rx_ferr && !rx_perr) begin
				rx_full_flag <= 1'b1;
			end else if (stat_wr && !hwdata[SRU_ST_FULL]) begin
				rx_full_flag <= 1'b0;
			end
			if (rx_done && rx_full_flag) begin
				overrun_flag <= 1'b1;
			end else if (stat_wr && !hwdata[SRU_ST_OVR]) begin
				overrun_flag <= 1'b0;
			end
			if (rx_done && rx_ferr) begin
				framing_flag <= 1'b1;
			end else if (stat_wr && !hwdata[SRU_ST_FRM]) begin
				framing_flag <= 1'b0;
			end
			if (rx_done && rx_perr) begin
				parity_flag <= 1'b1;
			end else if (stat_wr && !hwdata[SRU_ST_PAR]) begin
				parity_flag <= 1'b0;
			end
		end
	end

	// ********************
	// transmitter
	// ********************
	assign tx_load = tx_st == SRU_IDLE && serial_control_reg[SRU_CT_TXEN] && !tx_empty;
	assign tx_step = tick && tx_ph == SRU_OVS_LAST;

	// a write to the holding byte in the load cycle keeps it full
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_empty <= 1'b1;
		end else if (bus_wr && wr_addr == SRU_OFS_TXH) begin
			tx_empty <= 1'b0;
		end else if (tx_load) begin
			tx_empty <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_st <= SRU_IDLE;
			tx_ph <= 4'h0;
			tx_bit <= 3'h0;
			tx_shifter <= 8'h00;
			txd <= 1'b1;
			tx_par_acc <= 1'b0;
		end else begin
			if (tick) tx_ph <= tx_ph + 4'h1;
			unique case (tx_st)
				SRU_IDLE: begin
					txd <= 1'b1;
					if (tx_load) begin
						tx_shifter <= tx_holding_byte;
						tx_par_acc <= ^tx_holding_byte;
						tx_st <= SRU_START;
						tx_ph <= 4'h0;
						txd <= 1'b0;
					end
				end
				SRU_START: begin
					if (tx_step) begin
						tx_st <= SRU_DATA;
						tx_bit <= 3'h0;
						txd <= tx_shifter[0];
					end
				end
				SRU_DATA: begin
					if (tx_step) begin
						tx_bit <= tx_bit + 3'h1;
						tx_shifter <= {1'b0, tx_shifter[7:1]};
						if (tx_bit == SRU_BIT_LAST) begin
							if (serial_control_reg[SRU_CT_PEN]) begin
								tx_st <= SRU_PARITY;
								txd <= tx_par_acc ^ serial_control_reg[SRU_CT_ODD];
							end else begin
								tx_st <= SRU_STOP;
								txd <= 1'b1;
							end
						end else begin
							txd <= tx_shifter[1];
						end
					end
				end
				SRU_PARITY: begin
					if (tx_step) begin
						tx_st <= SRU_STOP;
						txd <= 1'b1;
					end
				end
				SRU_STOP: begin
					if (tx_step) tx_st <= SRU_IDLE;
				end
				default: tx_st <= SRU_IDLE;
			endcase
		end
	end

	// ********************
	// checks
	// ********************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	rx_store_a: assert property (rx_done && !rx_full_flag
		|=> received_byte == $past(rx_shifter)) else $error("byte not stored");
	rx_rearm_a: assert property (rx_done |=> rx_st == SRU_IDLE) else $error("rx not rearmed");
	rxb_ro_a: assert property (!$past(rx_done) && $past(rst_n)
		|-> $stable(received_byte)) else $error("received byte changed");
	tx_lsb_a: assert property (tx_st == SRU_START && tx_step
		|=> txd == $past(tx_shifter[0])) else $error("lsb not first");
	err_keep_a: assert property (rx_done && (rx_ferr || rx_perr)
		|=> rx_full_flag == $past(rx_full_flag)) else $error("full flag moved");
	err_halt_a: assert property (err_any && rx_st == SRU_IDLE
		|=> rx_st == SRU_IDLE) else $error("rx resumed on error");
	ovr_drop_a: assert property (rx_done && rx_full_flag
		|=> overrun_flag && $stable(received_byte)) else $error("overrun kept");
	frm_set_a: assert property (rx_done && rx_ferr && !rx_full_flag
		|=> framing_flag && !overrun_flag[*1]) else $error("framing flag");
	flag_hold_a: assert property (!stat_wr && !rx_done
		|=> $stable(overrun_flag) && $stable(framing_flag) && $stable(parity_flag))
		else $error("flag changed alone");

	rx_ok_c: cover property (rx_done && !rx_full_flag && !rx_ferr);
	rx_ovr_c: cover property (rx_done && rx_full_flag);
	tx_frame_c: cover property (tx_st == SRU_STOP && tx_step);
	rx_b2b_c: cover property (rx_done ##[1:40] rx_st == SRU_START);
endmodule : sru_async_serial_unit

// ==== core/sru_pkg.sv ====
// constants for the async serial unit: register map, fields, resets
// assumes a 32-bit ahb-lite bus and a single system clock
package sru_pkg;
	// ********************
	// register map
	// ********************
	localparam logic [7:0] SRU_OFS_RXB = 8'h00;
	localparam logic [7:0] SRU_OFS_TXH = 8'h04;
	localparam logic [7:0] SRU_OFS_STAT = 8'h08;
	localparam logic [7:0] SRU_OFS_CTRL = 8'h0C;
	localparam logic [7:0] SRU_OFS_RATE = 8'h10;
	// ********************
	// status and control fields
	// ********************
	localparam int SRU_ST_FULL = 0;
	localparam int SRU_ST_OVR = 1;
	localparam int SRU_ST_FRM = 2;
	localparam int SRU_ST_PAR = 3;
	localparam int SRU_ST_TXE = 4;
	localparam int SRU_ST_BUSY = 5;
	localparam int SRU_CT_RXEN = 0;
	localparam int SRU_CT_TXEN = 1;
	localparam int SRU_CT_PEN = 2;
	localparam int SRU_CT_ODD = 3;
	// ********************
	// reset values and timing
	// ********************
	localparam logic [7:0] SRU_RXB_RST = 8'h00;
	localparam logic [7:0] SRU_TXH_RST = 8'h00;
	localparam logic [3:0] SRU_CTRL_RST = 4'h0;
	localparam logic [15:0] SRU_RATE_RST = 16'h0000;
	localparam logic [3:0] SRU_OVS_LAST = 4'hF;
	localparam logic [3:0] SRU_OVS_MID = 4'h7;
	localparam logic [2:0] SRU_BIT_LAST = 3'h7;
	localparam logic [1:0] SRU_HTRANS_NONSEQ = 2'h2;
	typedef enum logic [2:0] {
		SRU_IDLE = 3'b000,
		SRU_START = 3'b001,
		SRU_DATA = 3'b010,
		SRU_PARITY = 3'b011,
		SRU_STOP = 3'b100
	} sru_state_e;
endpackage : sru_pkg

// ==== dv/sru_async_serial_unit_bench.sv ====
// bench for the async serial unit: ahb-lite master tasks, peer on the pins
// assumes the peer model and zero-wait bus answers within the watchdog span
`timescale 1ns/1ps
module sru_async_serial_unit_bench;
	import sru_pkg::*;
	localparam logic [31:0] ST = 32'h0000_000F;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	typedef struct {logic [7:0] d; logic [3:0] m;} sru_row_s;
	sru_row_s rows[4] = '{'{8'hA5, 4'h0}, '{8'h01, 4'h1}, '{8'h80, 4'h3}, '{8'hFF, 4'h0}};
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic hready;
	logic hresp;
	logic rxd;
	logic txd;
	logic par_en = 1'b0;
	int bad_count = 0;
	int comparisons = 0;
	int n;
	sru_async_serial_unit sru_async_serial_unit_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
		.hresp(hresp), .rxd(rxd), .txd(txd));
	sru_serial_peer sru_serial_peer_inst (.ref_clk(ref_clk), .txd(txd), .rxd(rxd),
		.par_en(par_en));
	initial forever #2 ref_clk = ~ref_clk;
	// ********
	// tasks
	// ********
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= SRU_HTRANS_NONSEQ;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		do @(posedge ref_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge ref_clk); while (hready !== 1'b1);
		rd = hrdata;
		check({31'h0000_0000, hresp}, 32'h0000_0000);
	endtask : bus
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic expect_reg(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		check(rd & mk, e);
	endtask : expect_reg
	task automatic rx(input logic [7:0] d, input logic [3:0] m);
		sru_serial_peer_inst.send(d, m);
		repeat (8) @(posedge ref_clk);
	endtask : rx
	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run
	// ********
	// sequence
	// ********
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		complete_run();
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		expect_reg(SRU_OFS_RXB, ALL, 32'h0000_0000);
		bus(1'b1, SRU_OFS_RXB, 32'h0000_00A5);
		expect_reg(SRU_OFS_RXB, ALL, 32'h0000_0000);
		expect_reg(8'h14, ALL, 32'h0000_0000);
		foreach (rows[i]) begin
			par_en <= rows[i].m[0];
			bus(1'b1, SRU_OFS_CTRL, {28'h000_0000, rows[i].m[1:0], 2'b11});
			rx(rows[i].d, rows[i].m);
			expect_reg(SRU_OFS_STAT, ST, 32'h0000_0001);
			expect_reg(SRU_OFS_RXB, ALL, {24'h00_0000, rows[i].d});
			bus(1'b1, SRU_OFS_STAT, 32'h0000_0000);
			n = sru_serial_peer_inst.got_cnt;
			bus(1'b1, SRU_OFS_TXH, {24'h00_0000, rows[i].d});
			repeat (4) @(posedge ref_clk);
			expect_reg(SRU_OFS_STAT, 32'h0000_0030, 32'h0000_0030);
			while (sru_serial_peer_inst.got_cnt == n) @(posedge ref_clk);
			check({24'h00_0000, sru_serial_peer_inst.got}, {24'h00_0000, rows[i].d});
			if (rows[i].m[0]) begin
				check({31'h0000_0000, sru_serial_peer_inst.got_par},
					{31'h0000_0000, ^rows[i].d ^ rows[i].m[1]});
			end
			repeat (16) @(posedge ref_clk);
			expect_reg(SRU_OFS_STAT, 32'h0000_0030, 32'h0000_0010);
		end
		par_en <= 1'b0;
		bus(1'b1, SRU_OFS_CTRL, 32'h0000_0003);
		// second frame starts the cycle after the first stop bit
		sru_serial_peer_inst.send(8'h3C, 4'h0);
		fork
			rx(8'hC3, 4'h0);
			begin
				expect_reg(SRU_OFS_RXB, ALL, 32'h0000_003C);
				bus(1'b1, SRU_OFS_STAT, 32'h0000_0000);
			end
		join
		expect_reg(SRU_OFS_STAT, ST, 32'h0000_0001);
		expect_reg(SRU_OFS_RXB, ALL, 32'h0000_00C3);
		rx(8'h5A, 4'h0);
		expect_reg(SRU_OFS_STAT, ST, 32'h0000_0003);
		expect_reg(SRU_OFS_RXB, ALL, 32'h0000_00C3);
		rx(8'h77, 4'h0);
		expect_reg(SRU_OFS_RXB, ALL, 32'h0000_00C3);
		bus(1'b1, SRU_OFS_STAT, 32'h0000_000F);
		expect_reg(SRU_OFS_STAT, ST, 32'h0000_0003);
		bus(1'b1, SRU_OFS_STAT, 32'h0000_0000);
		expect_reg(SRU_OFS_STAT, ST, 32'h0000_0000);
		rx(8'h77, 4'h0);
		expect_reg(SRU_OFS_RXB, ALL, 32'h0000_0077);
		rx(8'h88, 4'h8);
		expect_reg(SRU_OFS_STAT, ST, 32'h0000_0007);
		expect_reg(SRU_OFS_RXB, ALL, 32'h0000_0077);
		bus(1'b1, SRU_OFS_STAT, 32'h0000_0000);
		rx(8'h99, 4'h8);
		expect_reg(SRU_OFS_STAT, ST, 32'h0000_0004);
		expect_reg(SRU_OFS_RXB, ALL, 32'h0000_0099);
		bus(1'b1, SRU_OFS_STAT, 32'h0000_0000);
		bus(1'b1, SRU_OFS_CTRL, 32'h0000_0007);
		rx(8'h66, 4'h5);
		expect_reg(SRU_OFS_STAT, ST, 32'h0000_0008);
		expect_reg(SRU_OFS_RXB, ALL, 32'h0000_0066);
		bus(1'b1, SRU_OFS_STAT, 32'h0000_0000);
		bus(1'b1, SRU_OFS_CTRL, 32'h0000_000F);
		rx(8'hE1, 4'hF);
		expect_reg(SRU_OFS_STAT, ST, 32'h0000_000C);
		expect_reg(SRU_OFS_RXB, ALL, 32'h0000_00E1);
		// reset in mid-run with flags and a stored byte standing
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		expect_reg(SRU_OFS_RXB, ALL, 32'h0000_0000);
		expect_reg(SRU_OFS_STAT, ALL, 32'h0000_0010);
		expect_reg(SRU_OFS_CTRL, ALL, 32'h0000_0000);
		complete_run();
	end
endmodule : sru_async_serial_unit_bench

// ==== dv/sru_serial_peer.sv ====
// remote serial peer: sends frames on rxd, decodes frames seen on txd
// assumes bit_rate_reg at reset, so one bit lasts 16 ref_clk cycles
`timescale 1ns/1ps
module sru_serial_peer #(
	parameter int BIT = 16
) (
	// clock and pins
	input wire logic ref_clk,
	input wire logic txd,
	output logic rxd,
	// decoder setup
	input wire logic par_en
);
	logic [7:0] got;
	logic got_par;
	int got_cnt = 0;
	initial rxd = 1'b1;
	// m: {bad stop, bad parity, odd, parity on}
	task automatic send(input logic [7:0] d, input logic [3:0] m);
		logic [10:0] f;
		f = m[0] ? {~m[3], ^d ^ m[1] ^ m[2], d, 1'b0} : {1'b1, ~m[3], d, 1'b0};
		for (int i = 0; i < 10 + m[0]; i++) begin
			rxd <= f[i];
			repeat (BIT) @(posedge ref_clk);
		end
		// good stop already leaves the line idle; no second write at the seam
		if (m[3]) begin
			rxd <= 1'b1;
		end
	endtask
	always begin
		@(negedge txd);
		repeat (BIT / 2) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge ref_clk);
			got[i] = txd;
		end
		// mid parity bit when parity is on, mid stop bit otherwise
		repeat (BIT) @(posedge ref_clk);
		got_par = txd;
		repeat (BIT * par_en) @(posedge ref_clk);
		got_cnt++;
	end
endmodule : sru_serial_peer
